// ### hwdec_pkg.sv
// Package with the encodings, classes and operation codes of the halfword decoder.
// Behaviour
// - Bits 15:11 of 11101, 11110 or 11111 mark the first half of a wide instruction.
// - 00xxxx shift/add/move/compare, 010000 data processing, 010001 special data.
// - 01001x is a word load from the literal pool relative to the program counter.
// - 0101xx, 011xxx and 100xxx all go to the single load/store class.
// - 10100x makes a pc-relative address, 10101x a stack-relative address.
// - 1011xx is miscellaneous; unallocated encodings there raise undefined.
// - 11000x is a store multiple, 11001x a load multiple.
// - 1101xx is conditional branch or supervisor call; 11100x an unconditional branch.
// - Sub-opcode 000xx shift left, 001xx shift right, 010xx arithmetic shift right.
// - 01100/01101 register add/subtract, 01110/01111 three-bit immediate add/subtract.
// - 100xx move, 101xx compare, 110xx/111xx eight-bit immediate add/subtract.
// - Shift-left code 00000 with bits 8:6 zero is a register move instead.
// - Data codes 0000..0111: and, xor, shifts left, right, arith, carry add, carry sub, rotate.
// - Data codes 1000..1111: test, negate, compare, compare negative, or, multiply, clear, not.
// - Special 00xx add, 10xx move, 0101/011x compare, 0100 unpredictable.
// - Special 110x branch-exchange, 111x branch-link-exchange to a register.
// - Major 0101: minor 000..111 select eight register-offset loads and stores.
// - Major 0110/0111/1000: word/byte/half immediate; bit 11 picks store or load.
// - Major 1001: minor 0xx stack-relative word store, 1xx word load.
package hwdec_pkg;

  // ----------------------------------------------------------------
  // Field positions.
  // ----------------------------------------------------------------
  localparam int SEL_HI = 15;
  localparam int SEL_LO = 10;
  localparam int WIDE_LO = 11;
  localparam int SUB5_LO = 9;
  localparam int SUB4_LO = 6;
  localparam int MAJ_LO = 12;
  localparam int MIN_LO = 9;
  localparam int SIX_HI = 8;
  localparam int SIX_LO = 6;
  localparam int LS_DIR_BIT = 11;

  localparam logic [4:0] WIDE_A = 5'h1D;
  localparam logic [4:0] WIDE_B = 5'h1E;
  localparam logic [4:0] WIDE_C = 5'h1F;

  localparam logic [3:0] MAJ_REG = 4'h5;
  localparam logic [3:0] MAJ_WORD = 4'h6;
  localparam logic [3:0] MAJ_BYTE = 4'h7;
  localparam logic [3:0] MAJ_HALF = 4'h8;
  localparam logic [3:0] MAJ_STACK = 4'h9;

  localparam logic [3:0] SPEC_UNPRED = 4'h4;
  localparam logic [3:0] SPEC_COMPARE = 4'h5;

  // Miscellaneous-class allocated patterns use bits 11:5.
  localparam logic [6:0] MISC_CPS = 7'h33;

  // ----------------------------------------------------------------
  // Classes and operations.
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    CLS_SHIFT_ADD = 4'h0,
    CLS_DATA_PROC = 4'h1,
    CLS_SPECIAL = 4'h2,
    CLS_LIT_LOAD = 4'h3,
    CLS_LOAD_STORE = 4'h4,
    CLS_PC_ADDR = 4'h5,
    CLS_SP_ADDR = 4'h6,
    CLS_MISC = 4'h7,
    CLS_STORE_MULTI = 4'h8,
    CLS_LOAD_MULTI = 4'h9,
    CLS_COND_BRANCH = 4'hA,
    CLS_BRANCH = 4'hB,
    CLS_WIDE = 4'hC
  } hwdec_class_e;

  typedef enum logic [5:0] {
    OP_NONE = 6'h00,
    OP_SHIFT_LEFT_LOGICAL = 6'h01,
    OP_SHIFT_RIGHT_LOGICAL = 6'h02,
    OP_SHIFT_RIGHT_ARITH = 6'h03,
    OP_ADD_REG = 6'h04,
    OP_SUB_REG = 6'h05,
    OP_ADD_IMM3 = 6'h06,
    OP_SUB_IMM3 = 6'h07,
    OP_MOVE_IMM = 6'h08,
    OP_COMPARE_IMM = 6'h09,
    OP_ADD_IMM8 = 6'h0A,
    OP_SUB_IMM8 = 6'h0B,
    OP_MOVE_REG = 6'h0C,
    OP_AND = 6'h0D,
    OP_EXCLUSIVE_OR = 6'h0E,
    OP_SHIFT_LEFT_REG = 6'h0F,
    OP_SHIFT_RIGHT_REG = 6'h10,
    OP_SHIFT_ARITH_REG = 6'h11,
    OP_ADD_CARRY = 6'h12,
    OP_SUBTRACT_CARRY = 6'h13,
    OP_ROTATE_RIGHT = 6'h14,
    OP_TEST_AND = 6'h15,
    OP_REVERSE_SUBTRACT = 6'h16,
    OP_COMPARE_REG = 6'h17,
    OP_COMPARE_NEGATIVE = 6'h18,
    OP_BITWISE_OR = 6'h19,
    OP_MULTIPLY = 6'h1A,
    OP_BIT_CLEAR = 6'h1B,
    OP_BITWISE_NOT = 6'h1C,
    OP_BRANCH_EXCHANGE = 6'h1D,
    OP_BRANCH_LINK_EXCHANGE = 6'h1E,
    OP_STORE_WORD = 6'h1F,
    OP_STORE_HALF = 6'h20,
    OP_STORE_BYTE = 6'h21,
    OP_LOAD_SIGNED_BYTE = 6'h22,
    OP_LOAD_WORD = 6'h23,
    OP_LOAD_HALF = 6'h24,
    OP_LOAD_BYTE = 6'h25,
    OP_LOAD_SIGNED_HALF = 6'h26,
    OP_LOAD_LITERAL = 6'h27,
    OP_PC_ADDRESS = 6'h28,
    OP_SP_ADDRESS = 6'h29,
    OP_STORE_MULTIPLE = 6'h2A,
    OP_LOAD_MULTIPLE = 6'h2B,
    OP_BRANCH = 6'h2C,
    OP_MISC = 6'h2D,
    OP_COND_BRANCH = 6'h2E,
    OP_WIDE_PREFIX = 6'h2F
  } hwdec_op_e;

endpackage : hwdec_pkg

// ### hwdec_misc_chk.sv
// Allocation check for the miscellaneous 16-bit class.
`timescale 1ns/1ps
`default_nettype none
module hwdec_misc_chk
  import hwdec_pkg::*;
(
  input wire logic [6:0] misc_code,
  output logic allocated
);

  // ----------------------------------------------------------------
  // Allocation table.
  // ----------------------------------------------------------------
  // Gaps are 0110xxx except CPS, 0111xxx, 1000xxx and 101010x.
  always_comb begin
    allocated = 1'b1;
    if (misc_code[6:3] == 4'h6 && misc_code != MISC_CPS) begin
      allocated = 1'b0;
    end
    if (misc_code[6:3] == 4'h7 || misc_code[6:3] == 4'h8) begin
      allocated = 1'b0;
    end
    if (misc_code[6:1] == 6'h2A) begin
      allocated = 1'b0;
    end
  end

endmodule : hwdec_misc_chk
`default_nettype wire

// ### hwdec_top.sv
// Registered decoder for one compact halfword instruction.
`timescale 1ns/1ps
`default_nettype none
module hwdec_top
  import hwdec_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RSTN,
  input wire logic INSTR_VALID,
  input wire logic [15:0] INSTR_HALF,
  output logic DEC_VALID,
  output logic [3:0] DEC_CLASS,
  output logic [5:0] DEC_OP,
  output logic DEC_WIDE,
  output logic DEC_UNDEFINED,
  output logic DEC_UNPREDICTABLE
);

  // ----------------------------------------------------------------
  // State.
  // ----------------------------------------------------------------
  typedef struct packed {
    logic rst_meta;
    logic rst_sync;
    logic valid;
    hwdec_class_e cls;
    hwdec_op_e op;
    logic wide;
    logic undef;
    logic unpred;
  } hwdec_state_s;

  hwdec_state_s st_r;
  hwdec_state_s st_nxt;
  logic rst_n_int;
  logic misc_ok;
  logic [5:0] sel;
  logic [4:0] sub5;
  logic [3:0] sub4;
  logic [3:0] ls_major_field;
  logic [2:0] ls_minor_field;

  assign rst_n_int = st_r.rst_sync;
  assign sel = INSTR_HALF[SEL_HI:SEL_LO];
  assign sub5 = INSTR_HALF[13:SUB5_LO];
  assign sub4 = INSTR_HALF[SUB5_LO:SUB4_LO];
  assign ls_major_field = INSTR_HALF[SEL_HI:MAJ_LO];
  assign ls_minor_field = INSTR_HALF[LS_DIR_BIT:MIN_LO];

  hwdec_misc_chk u_misc (
    .misc_code(INSTR_HALF[11:5]),
    .allocated(misc_ok)
  );

  // ----------------------------------------------------------------
  // Decode.
  // ----------------------------------------------------------------
  // The halfword comes from fetch logic on this clock, so it is not synchronised.
  always_comb begin
    st_nxt = st_r;
    st_nxt.rst_meta = 1'b1;
    st_nxt.rst_sync = st_r.rst_meta;
    st_nxt.valid = INSTR_VALID;
    st_nxt.cls = CLS_SHIFT_ADD;
    st_nxt.op = OP_NONE;
    st_nxt.wide = 1'b0;
    st_nxt.undef = 1'b0;
    st_nxt.unpred = 1'b0;
    if (INSTR_HALF[SEL_HI:WIDE_LO] == WIDE_A || INSTR_HALF[SEL_HI:WIDE_LO] == WIDE_B ||
        INSTR_HALF[SEL_HI:WIDE_LO] == WIDE_C) begin
      st_nxt.wide = 1'b1;
      st_nxt.cls = CLS_WIDE;
      st_nxt.op = OP_WIDE_PREFIX;
    end else if (sel[5:4] == 2'h0) begin
      st_nxt.cls = CLS_SHIFT_ADD;
      casez (sub5)
        5'b000??: st_nxt.op = OP_SHIFT_LEFT_LOGICAL;
        5'b001??: st_nxt.op = OP_SHIFT_RIGHT_LOGICAL;
        5'b010??: st_nxt.op = OP_SHIFT_RIGHT_ARITH;
        5'b01100: st_nxt.op = OP_ADD_REG;
        5'b01101: st_nxt.op = OP_SUB_REG;
        5'b01110: st_nxt.op = OP_ADD_IMM3;
        5'b01111: st_nxt.op = OP_SUB_IMM3;
        5'b100??: st_nxt.op = OP_MOVE_IMM;
        5'b101??: st_nxt.op = OP_COMPARE_IMM;
        5'b110??: st_nxt.op = OP_ADD_IMM8;
        default: st_nxt.op = OP_SUB_IMM8;
      endcase
      if (sub5 == 5'h00 && INSTR_HALF[SIX_HI:SIX_LO] == 3'h0) begin
        st_nxt.op = OP_MOVE_REG;
      end
    end else if (sel == 6'h10) begin
      st_nxt.cls = CLS_DATA_PROC;
      unique case (sub4)
        4'h0: st_nxt.op = OP_AND;
        4'h1: st_nxt.op = OP_EXCLUSIVE_OR;
        4'h2: st_nxt.op = OP_SHIFT_LEFT_REG;
        4'h3: st_nxt.op = OP_SHIFT_RIGHT_REG;
        4'h4: st_nxt.op = OP_SHIFT_ARITH_REG;
        4'h5: st_nxt.op = OP_ADD_CARRY;
        4'h6: st_nxt.op = OP_SUBTRACT_CARRY;
        4'h7: st_nxt.op = OP_ROTATE_RIGHT;
        4'h8: st_nxt.op = OP_TEST_AND;
        4'h9: st_nxt.op = OP_REVERSE_SUBTRACT;
        4'hA: st_nxt.op = OP_COMPARE_REG;
        4'hB: st_nxt.op = OP_COMPARE_NEGATIVE;
        4'hC: st_nxt.op = OP_BITWISE_OR;
        4'hD: st_nxt.op = OP_MULTIPLY;
        4'hE: st_nxt.op = OP_BIT_CLEAR;
        4'hF: st_nxt.op = OP_BITWISE_NOT;
      endcase
    end else if (sel == 6'h11) begin
      st_nxt.cls = CLS_SPECIAL;
      // The deprecated stack pointer operand is left to software and decodes normally.
      casez (sub4)
        4'b00??: st_nxt.op = OP_ADD_REG;
        4'b10??: st_nxt.op = OP_MOVE_REG;
        4'b011?: st_nxt.op = OP_COMPARE_REG;
        4'b110?: st_nxt.op = OP_BRANCH_EXCHANGE;
        4'b111?: st_nxt.op = OP_BRANCH_LINK_EXCHANGE;
        default: begin
          if (sub4 == SPEC_COMPARE) begin
            st_nxt.op = OP_COMPARE_REG;
          end else begin
            st_nxt.unpred = 1'b1;
          end
        end
      endcase
    end else if (sel[5:1] == 5'h09) begin
      st_nxt.cls = CLS_LIT_LOAD;
      st_nxt.op = OP_LOAD_LITERAL;
    end else if (sel[5:2] == 4'h5 || sel[5:3] == 3'h3 || sel[5:3] == 3'h4) begin
      st_nxt.cls = CLS_LOAD_STORE;
      if (ls_major_field == MAJ_REG) begin
        unique case (ls_minor_field)
          3'h0: st_nxt.op = OP_STORE_WORD;
          3'h1: st_nxt.op = OP_STORE_HALF;
          3'h2: st_nxt.op = OP_STORE_BYTE;
          3'h3: st_nxt.op = OP_LOAD_SIGNED_BYTE;
          3'h4: st_nxt.op = OP_LOAD_WORD;
          3'h5: st_nxt.op = OP_LOAD_HALF;
          3'h6: st_nxt.op = OP_LOAD_BYTE;
          3'h7: st_nxt.op = OP_LOAD_SIGNED_HALF;
        endcase
      end else if (ls_major_field == MAJ_WORD || ls_major_field == MAJ_STACK) begin
        st_nxt.op = INSTR_HALF[LS_DIR_BIT] ? OP_LOAD_WORD : OP_STORE_WORD;
      end else if (ls_major_field == MAJ_BYTE) begin
        st_nxt.op = INSTR_HALF[LS_DIR_BIT] ? OP_LOAD_BYTE : OP_STORE_BYTE;
      end else begin
        st_nxt.op = INSTR_HALF[LS_DIR_BIT] ? OP_LOAD_HALF : OP_STORE_HALF;
      end
    end else if (sel[5:1] == 5'h14) begin
      st_nxt.cls = CLS_PC_ADDR;
      st_nxt.op = OP_PC_ADDRESS;
    end else if (sel[5:1] == 5'h15) begin
      st_nxt.cls = CLS_SP_ADDR;
      st_nxt.op = OP_SP_ADDRESS;
    end else if (sel[5:2] == 4'hB) begin
      st_nxt.cls = CLS_MISC;
      st_nxt.op = OP_MISC;
      st_nxt.undef = ~misc_ok;
    end else if (sel[5:1] == 5'h18) begin
      st_nxt.cls = CLS_STORE_MULTI;
      st_nxt.op = OP_STORE_MULTIPLE;
    end else if (sel[5:1] == 5'h19) begin
      st_nxt.cls = CLS_LOAD_MULTI;
      st_nxt.op = OP_LOAD_MULTIPLE;
    end else if (sel[5:2] == 4'hD) begin
      st_nxt.cls = CLS_COND_BRANCH;
      st_nxt.op = OP_COND_BRANCH;
    end else begin
      st_nxt.cls = CLS_BRANCH;
      st_nxt.op = OP_BRANCH;
    end
    if (!INSTR_VALID) begin
      st_nxt.undef = 1'b0;
      st_nxt.unpred = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Registers.
  // ----------------------------------------------------------------
  // The reset synchroniser bits share the struct but reset from the raw pin.
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      st_r <= '0;
    end else if (!rst_n_int) begin
      st_r <= '0;
      st_r.rst_meta <= 1'b1;
      st_r.rst_sync <= st_r.rst_meta;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign DEC_VALID = st_r.valid;
  assign DEC_CLASS = st_r.cls;
  assign DEC_OP = st_r.op;
  assign DEC_WIDE = st_r.wide;
  assign DEC_UNDEFINED = st_r.undef;
  assign DEC_UNPREDICTABLE = st_r.unpred;

  // ----------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!rst_n_int);

  // The release edge of the reset synchroniser still loads zeros, so every antecedent
  // also asks for the synchronised reset to be sampled high already.
  sequence s_wide_in;
    rst_n_int && INSTR_VALID && INSTR_HALF[15:13] == 3'h7 && INSTR_HALF[12:11] != 2'h0;
  endsequence

  a_wide_prefix_flag: assert property (s_wide_in |=> DEC_WIDE && DEC_CLASS == CLS_WIDE)
    else $error("wide prefix not flagged");
  a_narrow_not_wide: assert property ($past(rst_n_int) && !DEC_WIDE |->
      $past(INSTR_HALF[15:13]) != 3'h7 || $past(INSTR_HALF[12:11]) == 2'h0)
    else $error("wide flag missing");
  a_class_data_proc: assert property (rst_n_int && INSTR_HALF[15:10] == 6'h10 |=>
      DEC_CLASS == CLS_DATA_PROC)
    else $error("data class wrong");
  a_literal_load_op: assert property (rst_n_int && INSTR_HALF[15:11] == 5'h09 |=>
      DEC_OP == OP_LOAD_LITERAL)
    else $error("literal load wrong");
  a_load_store_class: assert property (rst_n_int &&
      INSTR_HALF[15:12] inside {4'h5, 4'h6, 4'h7, 4'h8, 4'h9} |=> DEC_CLASS == CLS_LOAD_STORE)
    else $error("load store class wrong");
  a_misc_undef_flag: assert property (rst_n_int && INSTR_VALID &&
      INSTR_HALF[15:12] == 4'hB && INSTR_HALF[11:8] == 4'h8 |=> DEC_UNDEFINED)
    else $error("undefined misc not flagged");
  a_reg_move_alias: assert property (rst_n_int && INSTR_HALF[15:6] == 10'h000 |=>
      DEC_OP == OP_MOVE_REG)
    else $error("register move alias wrong");
  a_mul_code_op: assert property (rst_n_int && INSTR_HALF[15:6] == 10'h10D |=>
      DEC_OP == OP_MULTIPLY)
    else $error("multiply decode wrong");
  a_spec_unpred_flag: assert property (rst_n_int && INSTR_VALID &&
      INSTR_HALF[15:6] == 10'h114 |=> DEC_UNPREDICTABLE ##1
      (!DEC_UNPREDICTABLE || $past(INSTR_HALF[15:6]) == 10'h114))
    else $error("unpredictable flag wrong");
  a_stack_load_dir: assert property (rst_n_int && INSTR_HALF[15:11] == 5'h13 |=>
      DEC_OP == OP_LOAD_WORD)
    else $error("stack load wrong");

endmodule : hwdec_top
`default_nettype wire

// ### hwdec_fetch_model.sv
// Fetch-side model that hands halfwords to the decoder.
`timescale 1ns/1ps
`default_nettype none
module hwdec_fetch_model (
  output logic instr_valid,
  output logic [15:0] instr_half
);
  initial begin
    instr_valid = 1'b0;
    instr_half = 16'hA5C3;
  end

  // Called at the falling edge only.
  // An idle slot shows the inverse of the last halfword, so stale data never looks settled.
  task automatic present(input logic v, input logic [15:0] h);
    logic [15:0] w;
    w = h;
    if ((w[15:8] == 8'h44 || w[15:8] == 8'h45) && w[6:3] == 4'hD) begin
      w[6:3] = 4'hC;
    end
    instr_valid = v;
    instr_half = v ? w : ~instr_half;
  endtask : present
endmodule : hwdec_fetch_model
`default_nettype wire

// ### hwdec_top_tb.sv
// Self-checking bench for the halfword decoder.
`timescale 1ns/1ps
`default_nettype none
module hwdec_top_tb
  import hwdec_pkg::*;
();
  typedef struct packed {
    logic [3:0] cls;
    logic [5:0] op;
    logic known;
    logic wide;
    logic undef;
    logic unpred;
  } hwdec_exp_s;

  localparam logic [15:0] CORNER [20] = '{16'h4340, 16'h0000, 16'h0040, 16'h4700,
    16'h4780, 16'h4540, 16'h4500, 16'h4600, 16'h4400, 16'h4468, 16'hE000, 16'hE800,
    16'hF000, 16'hF800, 16'hDF00, 16'hB660, 16'hB640, 16'hBA80, 16'h9800, 16'h9000};

  logic SYS_CLK;
  logic RSTN;
  logic INSTR_VALID;
  logic [15:0] INSTR_HALF;
  logic DEC_VALID;
  logic [3:0] DEC_CLASS;
  logic [5:0] DEC_OP;
  logic DEC_WIDE;
  logic DEC_UNDEFINED;
  logic DEC_UNPREDICTABLE;
  int error_cnt;
  int samples_checked;
  logic [31:0] lfsr_q;

  hwdec_fetch_model i_fetch (
    .instr_valid(INSTR_VALID),
    .instr_half(INSTR_HALF)
  );

  hwdec_top i_dut (
    .SYS_CLK(SYS_CLK),
    .RSTN(RSTN),
    .INSTR_VALID(INSTR_VALID),
    .INSTR_HALF(INSTR_HALF),
    .DEC_VALID(DEC_VALID),
    .DEC_CLASS(DEC_CLASS),
    .DEC_OP(DEC_OP),
    .DEC_WIDE(DEC_WIDE),
    .DEC_UNDEFINED(DEC_UNDEFINED),
    .DEC_UNPREDICTABLE(DEC_UNPREDICTABLE)
  );

  initial begin
    SYS_CLK = 1'b0;
    forever #5 SYS_CLK = ~SYS_CLK;
  end

  // ----------------------------------------------------------------
  // Expected decode.
  // ----------------------------------------------------------------
  function automatic logic [15:0] rnd();
    lfsr_q = {lfsr_q[30:0], 1'b0} ^ (lfsr_q[31] ? 32'h04C11DB7 : 32'h0);
    return lfsr_q[15:0];
  endfunction : rnd

  function automatic logic [5:0] shift_op(input logic [15:0] h);
    logic [4:0] s;
    s = h[13:9];
    case (s[4:2])
      3'h0: return (s == 5'h0 && h[8:6] == 3'h0) ? OP_MOVE_REG : OP_SHIFT_LEFT_LOGICAL;
      3'h1: return OP_SHIFT_RIGHT_LOGICAL;
      3'h2: return OP_SHIFT_RIGHT_ARITH;
      3'h3: return 6'(OP_ADD_REG) + {4'h0, s[1:0]};
      3'h4: return OP_MOVE_IMM;
      3'h5: return OP_COMPARE_IMM;
      3'h6: return OP_ADD_IMM8;
      default: return OP_SUB_IMM8;
    endcase
  endfunction : shift_op

  function automatic hwdec_exp_s expect_dec(input logic [15:0] h);
    hwdec_exp_s e;
    logic [5:0] s;
    logic [3:0] c;
    logic [6:0] m;
    e = '0;
    e.known = 1'b1;
    s = h[15:10];
    c = h[9:6];
    m = h[11:5];
    if (h[15:11] == 5'h1D || h[15:11] == 5'h1E || h[15:11] == 5'h1F) begin
      e.cls = CLS_WIDE;
      e.op = OP_WIDE_PREFIX;
      e.wide = 1'b1;
    end else if (s[5:4] == 2'h0) begin
      e.cls = CLS_SHIFT_ADD;
      e.op = shift_op(h);
    end else if (s == 6'h10) begin
      e.cls = CLS_DATA_PROC;
      e.op = 6'(OP_AND) + {2'h0, c};
    end else if (s == 6'h11) begin
      e.cls = CLS_SPECIAL;
      e.unpred = (c == 4'h4);
      e.known = !e.unpred;
      if (c[3:2] == 2'h0) e.op = OP_ADD_REG;
      else if (c[3:2] == 2'h1) e.op = OP_COMPARE_REG;
      else if (c[3:2] == 2'h2) e.op = OP_MOVE_REG;
      else e.op = c[1] ? OP_BRANCH_LINK_EXCHANGE : OP_BRANCH_EXCHANGE;
    end else if (s[5:1] == 5'h09) begin
      e.cls = CLS_LIT_LOAD;
      e.op = OP_LOAD_LITERAL;
    end else if (s[5:2] == 4'h5 || s[5:3] == 3'h3 || s[5:3] == 3'h4) begin
      e.cls = CLS_LOAD_STORE;
      if (h[15:12] == 4'h5) e.op = 6'(OP_STORE_WORD) + {3'h0, h[11:9]};
      else if (h[15:12] == 4'h7) e.op = h[11] ? OP_LOAD_BYTE : OP_STORE_BYTE;
      else if (h[15:12] == 4'h8) e.op = h[11] ? OP_LOAD_HALF : OP_STORE_HALF;
      else e.op = h[11] ? OP_LOAD_WORD : OP_STORE_WORD;
    end else if (s[5:1] == 5'h14) begin
      e.cls = CLS_PC_ADDR;
      e.op = OP_PC_ADDRESS;
    end else if (s[5:1] == 5'h15) begin
      e.cls = CLS_SP_ADDR;
      e.op = OP_SP_ADDRESS;
    end else if (s[5:2] == 4'hB) begin
      e.cls = CLS_MISC;
      e.op = OP_MISC;
      e.undef = (m[6:3] == 4'h6 && m != 7'h33) || m[6:3] == 4'h7 || m[6:3] == 4'h8
        || m[6:1] == 6'h2A;
    end else if (s[5:1] == 5'h18) begin
      e.cls = CLS_STORE_MULTI;
      e.op = OP_STORE_MULTIPLE;
    end else if (s[5:1] == 5'h19) begin
      e.cls = CLS_LOAD_MULTI;
      e.op = OP_LOAD_MULTIPLE;
    end else if (s[5:2] == 4'hD) begin
      e.cls = CLS_COND_BRANCH;
      e.op = OP_COND_BRANCH;
    end else begin
      e.cls = CLS_BRANCH;
      e.op = OP_BRANCH;
    end
    return e;
  endfunction : expect_dec

  // ----------------------------------------------------------------
  // Checks and drivers.
  // ----------------------------------------------------------------
  task automatic miss(input string msg);
    error_cnt++;
    $display("mismatch at %0t: %s for halfword %h", $time, msg, INSTR_HALF);
  endtask : miss

  task automatic chk_zero();
    samples_checked++;
    if ({DEC_VALID, DEC_CLASS, DEC_OP, DEC_WIDE, DEC_UNDEFINED, DEC_UNPREDICTABLE} !== 14'h0)
      miss("output not cleared in reset");
  endtask : chk_zero

  // At a falling edge the inputs still hold what the last rising edge sampled.
  task automatic chk_dec();
    hwdec_exp_s e;
    e = expect_dec(INSTR_HALF);
    samples_checked += 6;
    if (DEC_VALID !== INSTR_VALID) miss("valid copy");
    if (DEC_CLASS !== e.cls) miss("class code");
    if (e.known && DEC_OP !== e.op) miss("operation");
    if (INSTR_VALID === 1'b1 && DEC_WIDE !== e.wide) miss("wide prefix");
    if (DEC_UNDEFINED !== (INSTR_VALID & e.undef)) miss("undefined flag");
    if (DEC_UNPREDICTABLE !== (INSTR_VALID & e.unpred)) miss("unpredictable flag");
  endtask : chk_dec

  task automatic step(input logic v, input logic [15:0] h);
    @(negedge SYS_CLK);
    chk_dec();
    i_fetch.present(v, h);
  endtask : step

  task automatic do_reset();
    RSTN = 1'b0;
    #1;
    chk_zero();
    repeat (2) @(negedge SYS_CLK);
    chk_zero();
    RSTN = 1'b1;
    i_fetch.present(1'b1, 16'h4340);
    repeat (2) begin
      @(negedge SYS_CLK);
      chk_zero();
    end
  endtask : do_reset

  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : summarize

  initial begin
    #200000;
    miss("watchdog expired");
    summarize();
  end

  initial begin
    logic [15:0] r;
    RSTN = 1'b0;
    error_cnt = 0;
    samples_checked = 0;
    lfsr_q = 32'h05C255C3;
    @(negedge SYS_CLK);
    do_reset();
    foreach (CORNER[i]) step(1'b1, CORNER[i]);
    $display("corner test done");
    for (int s = 0; s < 64; s++) begin
      repeat (4) begin
        r = rnd();
        step(1'b1, {6'(s), r[9:0]});
      end
    end
    for (int c = 0; c < 128; c++) begin
      r = rnd();
      step(1'b1, {4'hB, 7'(c), r[4:0]});
    end
    for (int c = 0; c < 32; c++) begin
      r = rnd();
      step(1'b1, {2'h0, 5'(c), 3'h0, r[5:0]});
    end
    $display("sweep test done");
    repeat (2000) begin
      r = rnd();
      step(r[3] | r[7], rnd());
    end
    @(negedge SYS_CLK);
    chk_dec();
    $display("random test done");
    do_reset();
    repeat (40) begin
      r = rnd();
      step(r[2] | r[5], rnd());
    end
    @(negedge SYS_CLK);
    chk_dec();
    $display("second reset test done");
    summarize();
  end
endmodule : hwdec_top_tb
`default_nettype wire
